// file: rtl/rxf_avmm.sv
// avalon-mm slave holding the control register and the overflow counter view
`timescale 1ns/1ps
`include "rxf_regs.svh"
module rxf_avmm (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ovf_set,
  input wire logic [13:0] avail_bytes,
  input wire logic [15:0] ovf_count,
  output logic rx_en,
  output logic store_bad
);
  import rxf_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic wait_q; // high except in the single answer cycle
  logic [31:0] rdata_q; // read data latched in the first request cycle
  logic en_q; // receive enable
  logic sbf_q; // keep bad and filtered frames
  logic ovf_q; // sticky overflow flag

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire sel_ctrl = (avs_address == `RXF_OFF_CTRL);
  wire sel_cnt = (avs_address == `RXF_OFF_OVFCNT);
  wire wr_go = avs_write & ~wait_q; // a write acts only on the answering edge
  wire wr_ctrl = wr_go & sel_ctrl & avs_byteenable[0];
  wire [31:0] ctrl_view = {2'h0, avail_bytes, 11'h000, ovf_q, 2'h0, sbf_q, en_q};
  wire [31:0] rd_mux = sel_ctrl ? ctrl_view : (sel_cnt ? {16'h0000, ovf_count} : 32'h0000_0000);

  // one wait state: request seen, data latched, then waitrequest drops for a cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if ((avs_read | avs_write) & wait_q) begin
      wait_q <= 1'b0;
      rdata_q <= rd_mux;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // control bits; overflow flag cleared by writing one, a new overflow wins
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      en_q <= 1'b0;
      sbf_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        en_q <= avs_writedata[`RXF_CTRL_EN_BIT];
        sbf_q <= avs_writedata[`RXF_CTRL_SBF_BIT]; // [RQ11]
      end
      if (ovf_set) begin
        ovf_q <= 1'b1; // [RQ15]
      end else if (wr_ctrl & avs_writedata[`RXF_CTRL_OVF_BIT]) begin
        ovf_q <= 1'b0;
      end
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign rx_en = en_q;
  assign store_bad = sbf_q;

endmodule

// file: rtl/rxf_ctrl.sv
// receive frame fifo controller: store-and-forward buffer between filter engine and bulk-in unit
// Contract
// RQ1: buffer received frames in 12 KB ram
// RQ2: head sits two words before frame data
// RQ3: fill two reserved words with command words
// RQ4: third command word shares first data word
// RQ5: accept data after data ready, advance pointers
// RQ6: command words written last for a frame
// RQ7: frame invisible until fully written
// RQ8: read via pointer, head advances after success
// RQ9: deliver blocks of 1024/512/64 bytes by speed
// RQ10: overflow mid-frame rewinds the write pointers
// RQ11: discard bad/filtered frames unless store-bad set
// RQ12: report available data in control register
// RQ13: flag bulk-in unit when complete frame held
// RQ14: overflow raises receive overflow interrupt source
// RQ15: overflow sets status bit in control register
// RQ16: rewinds load pointer from matching head pointer
// RQ17: after overflow skip to next frame, count
// RQ18: bulk-in unit may rewind the read side
// RQ19: checksum-error frames always passed to host
// RQ20: pointers wrap; overflow when reaching read head
// RQ21: available count covers committed frames only
`timescale 1ns/1ps
`include "rxf_regs.svh"
module rxf_ctrl (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rfe_data_ready,
  input wire logic rfe_valid,
  input wire logic [31:0] rfe_data,
  input wire logic rfe_eof,
  input wire logic [15:0] rfe_cmd_c,
  input wire logic [31:0] rfe_cmd_a,
  input wire logic [31:0] rfe_cmd_b,
  input wire logic rfe_frame_err,
  input wire logic rfe_filtered,
  input wire logic rfe_csum_err,
  output logic rfe_ready,
  input wire rxf_pkg::rxf_speed_t usb_speed,
  input wire logic utx_block_req,
  input wire logic utx_commit,
  input wire logic utx_rewind,
  output logic utx_valid,
  output logic [31:0] utx_data,
  output logic utx_last,
  output logic utx_frame_avail,
  output logic recv_overflow_irq
);
  import rxf_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  rxf_wstate_t wst_q; // write side state
  rxf_rstate_t rst_q; // read side state
  rxf_ptr_t wr_ptr_q; // next data word location
  rxf_ptr_t wr_hd_q; // recv_write_head_pointer: start of frame being built
  rxf_ptr_t rd_ptr_q; // next word handed to the bulk-in unit
  rxf_ptr_t rd_hd_q; // recv_read_head_pointer: oldest word not yet acknowledged
  logic first_q; // next data word is the first of the frame
  logic ready_q; // ready toward the filter engine
  logic [31:0] cmd_a_q; // command words held until data is stored
  logic [31:0] cmd_b_q;
  logic [15:0] ovf_cnt_q; // overflow occurrences
  logic irq_q; // overflow interrupt source pulse
  logic [8:0] blk_cnt_q; // words sent in current block
  logic valid_q;
  logic last_q;
  logic [31:0] data_q;
  logic avail_q; // at least one committed frame present
  logic [13:0] avail_bytes_q; // committed bytes not yet acknowledged
  logic rx_en;
  logic store_bad;
  logic [31:0] ram_rd;

  // ----------------------------------------
  // write side decode
  // ----------------------------------------
  // a word is taken only while ready is up; the engine may stall at will
  wire take = rfe_valid & ready_q; // a word moves from the filter engine
  wire start = (wst_q == RXF_W_IDLE) & rfe_data_ready & rx_en; // [RQ5]
  // empty ram has wr_hd == rd_hd, so reserved slots never hit rd_hd then
  wire start_full = (wr_hd_q != rd_hd_q) &
                    ((rxf_ptr_add(wr_hd_q, 12'd1) == rd_hd_q) |
                     (rxf_ptr_add(wr_hd_q, `RXF_HEAD_GAP) == rd_hd_q)); // [RQ20]
  wire word_full = (rxf_ptr_add(wr_ptr_q, 12'd1) == rd_hd_q); // [RQ20]
  wire data_ovf = (wst_q == RXF_W_DATA) & take & word_full;
  // one overflow per frame: the state leaves data at once, so no second pulse
  wire ovf = (start & start_full) | data_ovf;
  // checksum errors are not in rfe_frame_err, so they never cause a drop
  wire drop_bad = ~store_bad & (rfe_frame_err | rfe_filtered); // [RQ11] [RQ19]
  // a full ram turns the store into a drop; that word is simply lost
  wire data_wr = (wst_q == RXF_W_DATA) & take & ~word_full;
  wire [31:0] data_word = first_q ? {rfe_data[31:16], rfe_cmd_c} : rfe_data; // [RQ4]

  // ram write port: data words while receiving, command words last
  wire ram_we = data_wr | (wst_q == RXF_W_CMDA) | (wst_q == RXF_W_CMDB); // [RQ6]
  wire rxf_ptr_t ram_widx = (wst_q == RXF_W_CMDA) ? wr_hd_q :
                            (wst_q == RXF_W_CMDB) ? rxf_ptr_add(wr_hd_q, 12'd1) :
                            wr_ptr_q; // [RQ3]
  wire [31:0] ram_wdata = (wst_q == RXF_W_CMDA) ? cmd_a_q :
                          (wst_q == RXF_W_CMDB) ? cmd_b_q : data_word;

  // ----------------------------------------
  // read side decode
  // ----------------------------------------
  // only committed words up to wr_hd are ever visible
  wire rd_more = (rd_ptr_q != wr_hd_q); // [RQ7]
  // the undefined speed code falls back to the smallest block
  wire [8:0] blk_words = (usb_speed == RXF_SPD_SS) ? `RXF_BLK_SS_WORDS :
                         (usb_speed == RXF_SPD_HS) ? `RXF_BLK_HS_WORDS :
                         `RXF_BLK_FS_WORDS; // [RQ9]
  // a block also ends at the last committed word, so short frames leave at once
  wire blk_end = ((blk_cnt_q + 9'd1) == blk_words) |
                 (rxf_ptr_add(rd_ptr_q, 12'd1) == wr_hd_q);
  wire rxf_ptr_t used_words = rxf_ptr_dist(wr_hd_q, rd_hd_q); // [RQ21]

  // ----------------------------------------
  // storage and register slave
  // ----------------------------------------
  // 3072 words of 32 bits make the 12 KB receive ram
  rxf_ram rxf_ram_inst ( // [RQ1]
    .mclk(mclk),
    .wr_en(ram_we),
    .wr_idx(ram_widx),
    .wr_data(ram_wdata),
    .rd_idx(rd_ptr_q),
    .rd_data(ram_rd)
  );

  // control and status live in their own slave; levels and the one-cycle overflow pulse cross here
  rxf_avmm rxf_avmm_inst (
    .mclk(mclk),
    .reset_n(reset_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .ovf_set(irq_q),
    .avail_bytes(avail_bytes_q),
    .ovf_count(ovf_cnt_q),
    .rx_en(rx_en),
    .store_bad(store_bad)
  );

  // ----------------------------------------
  // write side state machine
  // ----------------------------------------
  // the frame is built behind wr_hd; only the final step moves wr_hd
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wst_q <= RXF_W_IDLE;
      wr_ptr_q <= 12'h000;
      wr_hd_q <= 12'h000;
      first_q <= 1'b0;
      ready_q <= 1'b0;
      cmd_a_q <= 32'h0000_0000;
      cmd_b_q <= 32'h0000_0000;
    end else begin
      case (wst_q)
        RXF_W_IDLE: begin
          if (start) begin
            // two words left free at the head for the first command words
            wr_ptr_q <= rxf_ptr_add(wr_hd_q, `RXF_HEAD_GAP); // [RQ2]
            first_q <= 1'b1;
            ready_q <= 1'b1;
            wst_q <= start_full ? RXF_W_DROP : RXF_W_DATA; // [RQ10]
          end
        end
        RXF_W_DATA: begin
          if (take) begin
            if (word_full) begin
              wr_ptr_q <= wr_hd_q; // [RQ10] [RQ16]
              ready_q <= ~rfe_eof;
              wst_q <= rfe_eof ? RXF_W_IDLE : RXF_W_DROP; // [RQ17]
            end else if (rfe_eof & drop_bad) begin
              wr_ptr_q <= wr_hd_q; // [RQ11] [RQ16]
              ready_q <= 1'b0;
              wst_q <= RXF_W_IDLE;
            end else begin
              wr_ptr_q <= rxf_ptr_add(wr_ptr_q, 12'd1); // [RQ5]
              first_q <= 1'b0;
              if (rfe_eof) begin
                cmd_a_q <= rfe_cmd_a;
                cmd_b_q <= rfe_cmd_b;
                ready_q <= 1'b0;
                wst_q <= RXF_W_CMDA;
              end
            end
          end
        end
        RXF_W_DROP: begin
          // swallow the rest of a dropped frame; resume at the next one
          if (take & rfe_eof) begin
            ready_q <= 1'b0;
            wst_q <= RXF_W_IDLE; // [RQ17]
          end
        end
        RXF_W_CMDA: begin
          // command a fills the first reserved word at the head
          wst_q <= RXF_W_CMDB;
        end
        RXF_W_CMDB: begin
          // moving the head is the commit: the read side now sees the frame
          wr_hd_q <= wr_ptr_q; // [RQ7]
          wst_q <= RXF_W_IDLE;
        end
        default: begin
          ready_q <= 1'b0;
          wst_q <= RXF_W_IDLE;
        end
      endcase
    end
  end

  // overflow pulse and occurrence count; the counter saturates rather than wrap
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
      ovf_cnt_q <= 16'h0000;
    end else begin
      irq_q <= ovf; // [RQ14]
      if (ovf & (ovf_cnt_q != 16'hFFFF)) begin
        ovf_cnt_q <= ovf_cnt_q + 16'h0001; // [RQ17]
      end
    end
  end

  // ----------------------------------------
  // read side state machine
  // ----------------------------------------
  // rewind and commit act only between blocks, so a block never tears
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rst_q <= RXF_R_IDLE;
      rd_ptr_q <= 12'h000;
      rd_hd_q <= 12'h000;
      blk_cnt_q <= 9'h000;
      valid_q <= 1'b0;
      last_q <= 1'b0;
      data_q <= 32'h0000_0000;
    end else begin
      valid_q <= 1'b0;
      last_q <= 1'b0;
      case (rst_q)
        RXF_R_IDLE: begin
          // rewind beats commit so a lost packet is never acknowledged
          if (utx_rewind) begin
            rd_ptr_q <= rd_hd_q; // [RQ18] [RQ16]
          end else if (utx_commit) begin
            rd_hd_q <= rd_ptr_q; // [RQ8]
          end else if (utx_block_req & rd_more) begin
            blk_cnt_q <= 9'h000;
            rst_q <= RXF_R_SEND;
          end
        end
        RXF_R_SEND: begin
          valid_q <= 1'b1;
          data_q <= ram_rd; // [RQ8]
          rd_ptr_q <= rxf_ptr_add(rd_ptr_q, 12'd1);
          blk_cnt_q <= blk_cnt_q + 9'd1;
          if (blk_end) begin
            last_q <= 1'b1; // [RQ9]
            rst_q <= RXF_R_IDLE;
          end
        end
        default: begin
          rst_q <= RXF_R_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // status toward bulk-in unit and software
  // ----------------------------------------
  // wr_hd moves only on whole frames, so any gap means a complete frame
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      avail_q <= 1'b0;
      avail_bytes_q <= 14'h0000;
    end else begin
      avail_q <= (wr_hd_q != rd_hd_q); // [RQ13]
      avail_bytes_q <= {used_words, 2'b00}; // [RQ12] [RQ21]
    end
  end

  assign rfe_ready = ready_q;
  assign utx_valid = valid_q;
  assign utx_data = data_q;
  assign utx_last = last_q;
  assign utx_frame_avail = avail_q;
  assign recv_overflow_irq = irq_q;

endmodule

// file: rtl/rxf_pkg.sv
// types and pointer arithmetic of the receive frame fifo
`include "rxf_regs.svh"
package rxf_pkg;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef logic [`RXF_PTR_W-1:0] rxf_ptr_t;

  typedef enum logic [1:0] {
    RXF_SPD_FS = 2'h0,
    RXF_SPD_HS = 2'h1,
    RXF_SPD_SS = 2'h2
  } rxf_speed_t;

  typedef enum logic [2:0] {
    RXF_W_IDLE = 3'h0,
    RXF_W_DATA = 3'h1,
    RXF_W_DROP = 3'h2,
    RXF_W_CMDA = 3'h3,
    RXF_W_CMDB = 3'h4
  } rxf_wstate_t;

  typedef enum logic [0:0] {
    RXF_R_IDLE = 1'h0,
    RXF_R_SEND = 1'h1
  } rxf_rstate_t;

  // ----------------------------------------
  // circular pointer helpers
  // ----------------------------------------
  // advance a pointer by k words, wrapping at the end of the ram
  function automatic rxf_ptr_t rxf_ptr_add(input rxf_ptr_t p, input rxf_ptr_t k);
    logic [`RXF_PTR_W:0] s;
    s = {1'b0, p} + {1'b0, k};
    if (s >= {1'b0, `RXF_RAM_WORDS}) begin
      s = s - {1'b0, `RXF_RAM_WORDS};
    end
    return s[`RXF_PTR_W-1:0];
  endfunction

  // words from tail to head going forward
  function automatic rxf_ptr_t rxf_ptr_dist(input rxf_ptr_t head, input rxf_ptr_t tail);
    rxf_ptr_t d;
    if (head >= tail) begin
      d = head - tail;
    end else begin
      d = `RXF_RAM_WORDS - tail + head;
    end
    return d;
  endfunction

endpackage

// file: rtl/rxf_ram.sv
// flip-flop storage of the receive frame fifo, one write port, one indexed read port
`timescale 1ns/1ps
`include "rxf_regs.svh"
module rxf_ram (
  input wire logic mclk,
  input wire logic wr_en,
  input wire rxf_pkg::rxf_ptr_t wr_idx,
  input wire logic [31:0] wr_data,
  input wire rxf_pkg::rxf_ptr_t rd_idx,
  output logic [31:0] rd_data
);
  import rxf_pkg::*;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // data words carry no reset: pointers alone say what is valid
  logic [31:0] mem_q [0:`RXF_RAM_WORDS-1];

  // single write per cycle, index always in range since pointers wrap
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  // combinational read; the caller registers it
  assign rd_data = mem_q[rd_idx];

endmodule

// file: rtl/rxf_regs.svh
// register offsets, field positions, reset values and sizes of the receive frame fifo
`ifndef RXF_REGS_SVH
`define RXF_REGS_SVH

// ----------------------------------------
// storage geometry
// ----------------------------------------
`define RXF_RAM_BYTES 14'd12288
`define RXF_RAM_WORDS 12'd3072
`define RXF_PTR_W 12
`define RXF_HEAD_GAP 12'd2

// ----------------------------------------
// block sizes in bytes and in 32-bit words per usb speed
// ----------------------------------------
`define RXF_BLK_SS_BYTES 1024
`define RXF_BLK_HS_BYTES 512
`define RXF_BLK_FS_BYTES 64
`define RXF_BLK_SS_WORDS 9'(`RXF_BLK_SS_BYTES / 4)
`define RXF_BLK_HS_WORDS 9'(`RXF_BLK_HS_BYTES / 4)
`define RXF_BLK_FS_WORDS 9'(`RXF_BLK_FS_BYTES / 4)

// ----------------------------------------
// register word offsets (byte addresses)
// ----------------------------------------
`define RXF_OFF_CTRL 4'h0
`define RXF_OFF_OVFCNT 4'h4

// ----------------------------------------
// recv_fifo_control_reg fields
// ----------------------------------------
`define RXF_CTRL_EN_BIT 0
`define RXF_CTRL_SBF_BIT 1
`define RXF_CTRL_OVF_BIT 4
`define RXF_CTRL_AVAIL_LSB 16
`define RXF_CTRL_AVAIL_MSB 29
`define RXF_CTRL_RESET 32'h0000_0000

`endif

// file: sim/rxf_ctrl_monitor.sv
// port-level assertions of the receive frame fifo controller
`timescale 1ns/1ps
module rxf_ctrl_monitor (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic rfe_valid,
  input wire logic rfe_eof,
  input wire logic rfe_ready,
  input wire logic utx_block_req,
  input wire logic utx_valid,
  input wire logic utx_last,
  input wire logic utx_frame_avail,
  input wire logic recv_overflow_irq
);
  // -------------------------------------
  // one clock domain: clock and reset given once
  // -------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  bus_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait state");
  answer_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  unmapped_zero_a: assert property (
    avs_read && !avs_waitrequest && avs_address > 4'h4 |-> avs_readdata == 32'h0)
    else $error("unmapped address read nonzero");
  ready_drop_a: assert property (rfe_valid && rfe_ready && rfe_eof |=> !rfe_ready)
    else $error("ready still high after last word");
  // ready must last to eof even when an overflow has dropped the frame
  ready_hold_a: assert property (rfe_ready && !(rfe_valid && rfe_eof) |=> rfe_ready)
    else $error("ready dropped inside a frame");
  hidden_frame_a: assert property (rfe_ready && !utx_frame_avail |=> !utx_frame_avail)
    else $error("frame visible before its command words");
  irq_pulse_a: assert property (recv_overflow_irq |=> !recv_overflow_irq)
    else $error("overflow interrupt longer than one cycle");
  block_start_a: assert property (
    $rose(utx_valid) |-> $past(utx_block_req, 2) && utx_frame_avail)
    else $error("block data without request two cycles before");
  block_run_a: assert property (utx_valid && !utx_last |=> utx_valid)
    else $error("gap inside a block");
  last_valid_a: assert property (utx_last |-> utx_valid)
    else $error("last marker without valid");
endmodule

// file: sim/rxf_partner.sv
// far side: filter engine feeding frames, bulk-in unit pulling blocks
`timescale 1ns/1ps
module rxf_partner (
  input wire logic mclk,
  input wire logic rfe_ready,
  input wire logic utx_valid,
  input wire logic [31:0] utx_data,
  input wire logic utx_last,
  output logic rfe_data_ready,
  output logic rfe_valid,
  output logic [31:0] rfe_data,
  output logic rfe_eof,
  output logic [15:0] rfe_cmd_c,
  output logic [31:0] rfe_cmd_a,
  output logic [31:0] rfe_cmd_b,
  output logic rfe_frame_err,
  output logic rfe_filtered,
  output logic rfe_csum_err,
  output logic utx_block_req,
  output logic utx_commit,
  output logic utx_rewind
);
  logic [31:0] got [$]; // words of the last block taken
  initial begin
    {rfe_data_ready, rfe_valid, rfe_eof, rfe_frame_err, rfe_filtered, rfe_csum_err} = 6'h0;
    {utx_block_req, utx_commit, utx_rewind, rfe_data, rfe_cmd_a, rfe_cmd_b, rfe_cmd_c} = 115'h0;
  end
  // -------------------------------------
  // one frame: announce, then a word at each edge where ready is high
  // -------------------------------------
  task send_frame(input int n, input logic [31:0] b, input logic [2:0] fl, input int gap);
    int i;
    i = 0;
    rfe_data_ready <= 1'b1;
    @(posedge mclk);
    rfe_data_ready <= 1'b0;
    while (i < n) begin
      if (gap != 0 && i % gap == 1) begin
        // stall; an idle bus shows garbage, not the last word
        rfe_valid <= 1'b0;
        rfe_data <= ~rfe_data;
        @(posedge mclk);
      end
      rfe_valid <= 1'b1;
      rfe_data <= b + 32'(i);
      rfe_eof <= (i == n - 1);
      rfe_cmd_c <= b[15:0] ^ 16'h3C3C;
      rfe_cmd_a <= b ^ 32'h5A5A_0000;
      rfe_cmd_b <= ~b;
      {rfe_frame_err, rfe_filtered, rfe_csum_err} <= fl;
      @(posedge mclk);
      if (rfe_ready === 1'b1) begin
        i++;
      end
    end
    rfe_valid <= 1'b0;
    rfe_eof <= 1'b0;
    rfe_data <= ~rfe_data;
    // spacing to the next frame, also lets the commit settle
    repeat (4) @(posedge mclk);
  endtask
  // one-cycle pulse on {rewind, commit, request}
  task pulse(input logic [2:0] m);
    {utx_rewind, utx_commit, utx_block_req} <= m;
    @(posedge mclk);
    {utx_rewind, utx_commit, utx_block_req} <= 3'h0;
    @(posedge mclk);
  endtask
  // ask for one block and collect it up to the word marked last
  task read_block();
    logic done;
    done = 1'b0;
    got.delete();
    pulse(3'b001);
    while (!done) begin
      @(posedge mclk);
      if (utx_valid === 1'b1) begin
        got.push_back(utx_data);
        done = (utx_last === 1'b1);
      end
    end
  endtask
endmodule

// file: sim/tb_rx_frame_fifo_controller.sv
// self-checking bench of the receive frame fifo controller
`timescale 1ns/1ps
`include "rxf_regs.svh"
module tb_rx_frame_fifo_controller;
  import rxf_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, utx_data, rfe_data, rfe_cmd_a, rfe_cmd_b, rd;
  logic [15:0] rfe_cmd_c;
  logic avs_waitrequest, rfe_ready, utx_valid, utx_last, utx_frame_avail, recv_overflow_irq;
  logic rfe_data_ready, rfe_valid, rfe_eof, rfe_frame_err, rfe_filtered, rfe_csum_err;
  logic utx_block_req, utx_commit, utx_rewind;
  rxf_speed_t usb_speed = RXF_SPD_FS;
  logic [31:0] seed = 32'h5625; // fixed seed keeps runs repeatable
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int n_irq = 0;
  int n, f;
  rxf_ctrl rxf_ctrl_inst (.*);
  rxf_partner rxf_partner_inst (.*);
  always #10 mclk = ~mclk;
  // interrupt count and cycle ceiling against hangs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (recv_overflow_irq === 1'b1) begin
      n_irq <= n_irq + 1;
    end
    if (cycles == 60000) begin
      errors = errors + 1;
      finish_test();
    end
  end
  // -------------------------------------
  // helpers
  // -------------------------------------
  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // bus cycles hold the request until waitrequest is seen low
  task bus_wr(input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task bus_rd(input logic [3:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  // stored image: cmd a, cmd b, cmd c beside first two bytes, then data
  function logic [31:0] exp_word(input logic [31:0] b, input int idx);
    if (idx == 0) return b ^ 32'h5A5A_0000;
    if (idx == 1) return ~b;
    if (idx == 2) return {b[31:16], b[15:0] ^ 16'h3C3C};
    return b + 32'(idx - 2);
  endfunction
  function int blk_words(input rxf_speed_t s);
    if (s == RXF_SPD_SS) return `RXF_BLK_SS_BYTES / 4;
    if (s == RXF_SPD_HS) return `RXF_BLK_HS_BYTES / 4;
    return `RXF_BLK_FS_BYTES / 4;
  endfunction
  task cmp_block(input logic [31:0] b, input int off, input int len);
    check(32'(rxf_partner_inst.got.size()), 32'(len), "block length");
    foreach (rxf_partner_inst.got[j]) begin
      check(rxf_partner_inst.got[j], exp_word(b, off + j), "block word");
    end
  endtask
  // one frame in, then drained block by block; first block rewound and resent
  task frame_rt(input int len, input logic [2:0] fl, input logic keep, input int gap);
    logic [31:0] b;
    int off, w, cnt;
    b = $random(seed);
    off = 0;
    w = blk_words(usb_speed);
    rxf_partner_inst.send_frame(len, b, fl, gap);
    check(32'(utx_frame_avail), 32'(keep), "frame visible");
    if (keep) begin
      bus_rd(`RXF_OFF_CTRL, rd);
      check(32'(rd[29:16]), 32'((len + 2) * 4), "available bytes");
      while (off < len + 2) begin
        cnt = (len + 2 - off < w) ? len + 2 - off : w;
        rxf_partner_inst.read_block();
        cmp_block(b, off, cnt);
        if (off == 0) begin
          rxf_partner_inst.pulse(3'b100);
          rxf_partner_inst.read_block();
          cmp_block(b, off, cnt);
        end
        rxf_partner_inst.pulse(3'b010);
        off += cnt;
      end
      repeat (2) @(posedge mclk);
      check(32'(utx_frame_avail), 32'h0, "drained");
    end
  endtask
  task finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // -------------------------------------
  // main sequence
  // -------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    bus_rd(`RXF_OFF_CTRL, rd);
    check(rd, `RXF_CTRL_RESET, "control after reset");
    bus_wr(4'h8, 32'hFFFF_FFFF);
    bus_rd(4'h8, rd);
    check(rd, 32'h0, "unmapped");
    bus_wr(`RXF_OFF_CTRL, 32'h1);
    $display("test registers done");
    // every error flag mix, first dropping then storing bad frames
    for (f = 0; f < 16; f++) begin
      if (f == 8) begin
        bus_wr(`RXF_OFF_CTRL, 32'h3);
      end
      frame_rt(2 + f % 5, 3'(f), f >= 8 || f[2:1] == 2'b00, 0);
    end
    bus_wr(`RXF_OFF_CTRL, 32'h1);
    $display("test frame errors done");
    // each speed code with a frame just over one block
    for (f = 0; f < 4; f++) begin
      usb_speed <= rxf_speed_t'(f[1:0]);
      @(posedge mclk);
      frame_rt(blk_words(rxf_speed_t'(f[1:0])) + 3, 3'h0, 1'b1, 3);
    end
    $display("test block sizes done");
    // random traffic; the total passes the ram end at most twice
    for (f = 0; f < 40; f++) begin
      usb_speed <= rxf_speed_t'(2'({$random(seed)} % 3));
      @(posedge mclk);
      n = 1 + ({$random(seed)} % 150);
      frame_rt(n, 3'h0, 1'b1, {$random(seed)} % 4);
    end
    $display("test random traffic done");
    // a frame larger than the ram is dropped and flagged
    rxf_partner_inst.send_frame(3100, 32'h0, 3'h0, 0);
    check(32'(n_irq), 32'h1, "overflow interrupt");
    check(32'(utx_frame_avail), 32'h0, "overflowed frame gone");
    bus_rd(`RXF_OFF_CTRL, rd);
    check(32'(rd[4]), 32'h1, "overflow flag");
    bus_rd(`RXF_OFF_OVFCNT, rd);
    check({16'h0, rd[15:0]}, 32'h1, "overflow count");
    bus_wr(`RXF_OFF_CTRL, 32'h11);
    bus_rd(`RXF_OFF_CTRL, rd);
    check(32'(rd[4]), 32'h0, "flag cleared");
    frame_rt(40, 3'h0, 1'b1, 2);
    $display("test overflow done");
    finish_test();
  end
endmodule
bind rxf_ctrl rxf_ctrl_monitor rxf_ctrl_monitor_inst (.*);
